// >>> asu_consts.svh
// Constants for the asynchronous serial unit core
`ifndef ASU_CONSTS_SVH
`define ASU_CONSTS_SVH
`define ASU_MODE_OFFSET   16'hff50
`define ASU_CTRL_OFFSET   16'hff58
`define ASU_TXB_OFFSET    16'hff55
`define ASU_RXB_OFFSET    16'hff53
`define ASU_ERR_OFFSET    16'hff52
`define ASU_TSTAT_OFFSET  16'hff56
`define ASU_DIV_OFFSET    16'hff57
`define ASU_PORT1_OFFSET  16'hff21
`define ASU_MODE_RESET    8'h01
`define ASU_CTRL_RESET    8'h16
`define ASU_PORT1_RESET   8'hff
`define ASU_DIV_RESET     8'hff
`define ASU_DIV_MIN       8'h04
`define ASU_BIT_POWER     7
`define ASU_BIT_TXE       6
`define ASU_BIT_RXE       5
`define ASU_BIT_PSH       4
`define ASU_BIT_PSL       3
`define ASU_BIT_CL        2
`define ASU_BIT_SL        1
`define ASU_BIT_DIR       1
`define ASU_BIT_INV       0
`define ASU_BIT_TXPIN     3
`define ASU_BIT_RXPIN     4
`define ASU_BIT_PERR      2
`define ASU_BIT_FERR      1
`define ASU_BIT_OERR      0
`define ASU_CTRL_RW_MASK  8'h3f
`define ASU_OS            4'hf
`define ASU_OS_HALF       4'h7
`endif

// >>> asu_pkg.sv
// Types for the asynchronous serial unit core
package asu_pkg;
    typedef enum logic [4:0] {
        ASU_IDLE  = 5'b00001,
        ASU_START = 5'b00010,
        ASU_DATA  = 5'b00100,
        ASU_PAR   = 5'b01000,
        ASU_STOP  = 5'b10000
    } asu_state_e;
    typedef logic [7:0] asu_byte_t;
endpackage

// >>> asu_framer.sv
// Frame shifter shared by transmit and receive directions
`timescale 1ns/100ps
`include "asu_consts.svh"
module asu_framer (
    input  wire logic              clock,
    input  wire logic              clr,
    input  wire logic              tick,
    input  wire logic              is_rx,
    input  wire logic              go,
    input  wire asu_pkg::asu_byte_t din,
    input  wire logic              line_in,
    input  wire logic              len7,
    input  wire logic              lsb_first,
    input  wire logic [1:0]        par_mode,
    input  wire logic              stop2,
    output logic                   busy,
    output logic                   line_out,
    output logic                   done,
    output asu_pkg::asu_byte_t     dout,
    output logic                   par_err,
    output logic                   frm_err
);
    import asu_pkg::*;
    asu_state_e state_q;
    logic [3:0] os_q;
    logic [2:0] idx_q;
    logic       stop_q;
    logic [7:0] sh_q;
    logic       ones_q;
    wire        adv      = tick && (os_q == `ASU_OS);
    wire        mid      = tick && (os_q == `ASU_OS_HALF);
    wire [2:0]  last_idx = len7 ? 3'd6 : 3'd7;
    wire [2:0]  pos      = lsb_first ? idx_q : (last_idx - idx_q); // R15
    wire        has_par  = (par_mode != 2'b00);
    wire        odd_par  = (par_mode == 2'b10);
    wire        zero_par = (par_mode == 2'b11);
    // R19 R20 R21
    wire        tx_par   = zero_par ? 1'b0 : (ones_q ^ odd_par);
    wire        par_bad  = has_par && !zero_par && ((ones_q ^ line_in) != odd_par);
    assign busy = (state_q != ASU_IDLE);
    always_ff @(posedge clock) begin
        done <= 1'b0;
        if (clr) begin // R4 R5
            state_q  <= ASU_IDLE;
            os_q     <= 4'h0;
            idx_q    <= 3'd0;
            stop_q   <= 1'b0;
            sh_q     <= 8'h00;
            ones_q   <= 1'b0;
            line_out <= 1'b1;
            dout     <= 8'h00;
            par_err  <= 1'b0;
            frm_err  <= 1'b0;
        end else begin
            if (tick)
                os_q <= os_q + 4'h1;
            unique case (state_q)
                ASU_IDLE: begin
                    line_out <= 1'b1; // R18
                    if (!is_rx && go) begin // R11
                        sh_q     <= din;
                        ones_q   <= 1'b0;
                        idx_q    <= 3'd0;
                        os_q     <= 4'h0;
                        line_out <= 1'b0; // R13 R18
                        state_q  <= ASU_START;
                    end else if (is_rx && !line_in) begin
                        os_q    <= 4'h0;
                        ones_q  <= 1'b0;
                        idx_q   <= 3'd0;
                        // Stale parity flag would leak into a frame without parity
                        par_err <= 1'b0;
                        state_q <= ASU_START;
                    end
                end
                ASU_START: begin
                    if (is_rx && mid && line_in)
                        state_q <= ASU_IDLE;
                    else if (adv) begin
                        idx_q    <= 3'd0;
                        line_out <= sh_q[pos];
                        state_q  <= ASU_DATA;
                    end
                end
                ASU_DATA: begin
                    if (is_rx && mid) begin
                        sh_q[pos] <= line_in;
                        ones_q    <= ones_q ^ line_in;
                    end
                    if (adv) begin
                        if (!is_rx)
                            ones_q <= ones_q ^ sh_q[pos];
                        idx_q <= idx_q + 3'd1;
                        if (idx_q == last_idx) begin
                            stop_q   <= 1'b0;
                            line_out <= has_par ? (ones_q ^ sh_q[pos] ^ odd_par) & !zero_par
                                                : 1'b1;
                            state_q  <= has_par ? ASU_PAR : ASU_STOP;
                        end else
                            line_out <= sh_q[lsb_first ? idx_q + 3'd1 : last_idx - idx_q - 3'd1];
                    end
                end
                ASU_PAR: begin
                    if (is_rx && mid)
                        par_err <= par_bad;
                    if (!is_rx && adv)
                        line_out <= 1'b1;
                    else if (!is_rx)
                        line_out <= tx_par;
                    if (adv)
                        state_q <= ASU_STOP;
                end
                ASU_STOP: begin
                    line_out <= 1'b1; // R18
                    if (is_rx && mid) begin
                        frm_err <= !line_in;
                        dout    <= len7 ? {1'b0, sh_q[6:0]} : sh_q;
                        done    <= 1'b1;
                        state_q <= ASU_IDLE;
                    end else if (!is_rx && adv) begin
                        stop_q <= 1'b1;
                        if (!stop2 || stop_q) begin // R13
                            done    <= 1'b1;
                            state_q <= ASU_IDLE;
                        end
                    end
                end
                default: state_q <= ASU_IDLE;
            endcase
        end
    end
endmodule

// >>> asu_core.sv
// Asynchronous serial unit core: registers, pin muxing, transmit and receive
// Functional notes
// R1 - Power, transmit and receive enables all zero stop the unit; pins become ports.
// R2 - Reset loads mode control with 01h.
// R3 - Power zero holds internal clock low and resets circuitry.
// R4 - Transmit enable zero holds transmitter in synchronous reset.
// R5 - Receive enable zero holds receiver in synchronous reset.
// R6 - Power cleared mid-transmission: transmit pin high, receive input forced high; the transmit pin follows tx_pin_latch instead.
// R7 - Power zero resets error status, transmit status, break flags, receive buffer.
// R8 - Software clears enables before power; sets power before enables.
// R9 - One byte per frame; transmit and receive run concurrently.
// R10 - Software sets clock, divisor, format, order/inversion, power, enables in order.
// R11 - Writing the transmit buffer while enabled starts a frame.
// R12 - Each pin is serial only when power and its enable are set.
// R13 - Frame: start, 7 or 8 data bits, optional parity, 1 or 2 stops.
// R14 - Length, parity and stop count come from mode control fields.
// R15 - Order bit selects LSB or MSB first.
// R16 - Inversion bit selects normal or inverted transmit waveform.
// R17 - Direction bit zero makes output; transmit needs latch one, receive input.
// R18 - Line idles high; start low, stop high; inverted when selected.
// R19 - Even parity makes ones even; odd count on receive is error.
// R20 - Odd parity makes ones odd; even count on receive is error.
// R21 - Zero parity sends zero, never errors; no parity sends none.
// R22 - Inversion bit one inverts transmit output, zero leaves it.
`timescale 1ns/100ps
`include "asu_consts.svh"
module asu_core (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [15:0]        reg_addr,
    input  wire asu_pkg::asu_byte_t reg_wdata,
    output asu_pkg::asu_byte_t      reg_rdata,
    input  wire logic               tx_pin_latch,
    input  wire logic               rx_pin_latch,
    input  wire logic               serial_in_pin,
    output logic                    serial_out_pin,
    output logic                    serial_out_oe,
    output logic                    rx_pin_oe,
    output logic                    rx_pin_out,
    output logic                    tx_done_pulse,
    output logic                    rx_done_pulse
);
    import asu_pkg::*;
    asu_byte_t mode_q, ctrl_q, port1_q, div_q, txb_q, rxb_q, err_q;
    logic      txbf_q;
    logic [7:0] bcnt_q;
    logic      tick_q;
    wire power   = mode_q[`ASU_BIT_POWER];
    wire tx_on   = power && mode_q[`ASU_BIT_TXE]; // R12
    wire rx_on   = power && mode_q[`ASU_BIT_RXE]; // R12
    wire invert  = ctrl_q[`ASU_BIT_INV];
    wire wr_mode = reg_wr && (reg_addr == `ASU_MODE_OFFSET);
    wire wr_ctrl = reg_wr && (reg_addr == `ASU_CTRL_OFFSET);
    wire wr_port = reg_wr && (reg_addr == `ASU_PORT1_OFFSET);
    wire wr_div  = reg_wr && (reg_addr == `ASU_DIV_OFFSET);
    wire wr_txb  = reg_wr && (reg_addr == `ASU_TXB_OFFSET) && tx_on && !txbf_q;
    wire rd_rxb  = reg_rd && (reg_addr == `ASU_RXB_OFFSET);
    wire rd_err  = reg_rd && (reg_addr == `ASU_ERR_OFFSET);
    // Gated operation clock modelled as a tick that stays low while unpowered
    wire op_tick = power && tick_q; // R3
    wire tx_busy, tx_line, tx_done, rx_done, rx_perr, rx_ferr;
    asu_byte_t rx_data;
    // R6: receive input forced high when unpowered or unselected
    wire rx_line = rx_on ? serial_in_pin : 1'b1;
    wire tx_start = txbf_q && !tx_busy;
    wire [1:0] par_mode = {mode_q[`ASU_BIT_PSH], mode_q[`ASU_BIT_PSL]};
    // Divider gives 16 ticks per bit; divisor below the minimum clamps to it
    wire [7:0] div_lim = (div_q < `ASU_DIV_MIN) ? `ASU_DIV_MIN : div_q;
    always_ff @(posedge clock) begin
        if (rst || !power) begin // R3
            bcnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (bcnt_q == div_lim - 8'h01);
            bcnt_q <= (bcnt_q == div_lim - 8'h01) ? 8'h00 : bcnt_q + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q  <= `ASU_MODE_RESET; // R2
            ctrl_q  <= `ASU_CTRL_RESET;
            port1_q <= `ASU_PORT1_RESET;
            div_q   <= `ASU_DIV_RESET;
        end else begin
            if (wr_mode)
                mode_q <= reg_wdata;
            if (wr_ctrl)
                ctrl_q <= reg_wdata & `ASU_CTRL_RW_MASK; // R7
            if (wr_port)
                port1_q <= reg_wdata;
            if (wr_div)
                div_q <= reg_wdata;
        end
    end
    // Buffers and status; unpowered state clears them all
    always_ff @(posedge clock) begin
        if (rst || !power) begin // R7
            txb_q  <= 8'h00;
            txbf_q <= 1'b0;
            rxb_q  <= 8'h00;
            err_q  <= 8'h00;
        end else begin
            if (!tx_on) // R4
                txbf_q <= 1'b0;
            else if (wr_txb) begin // R11
                txb_q  <= reg_wdata;
                txbf_q <= 1'b1;
            end else if (tx_start)
                txbf_q <= 1'b0;
            // Buffer and errors survive a receive disable; power-off clears both, an error register read clears the errors
            if (rx_done) begin // R9
                rxb_q <= rx_data;
                // Set wins over a read-clear landing in the same cycle
                err_q <= {5'h00, rx_perr, rx_ferr, 1'b0} | (rd_err ? 8'h00 : err_q);
            end else if (rd_err)
                err_q <= 8'h00;
        end
    end
    asu_framer u_tx (
        .clock     (clock),
        .clr       (rst || !tx_on), // R4
        .tick      (op_tick),
        .is_rx     (1'b0),
        .go        (tx_start),
        .din       (txb_q),
        .line_in   (1'b1),
        .len7      (!mode_q[`ASU_BIT_CL]), // R14
        .lsb_first (ctrl_q[`ASU_BIT_DIR]),
        .par_mode  (par_mode),
        .stop2     (mode_q[`ASU_BIT_SL]),
        .busy      (tx_busy),
        .line_out  (tx_line),
        .done      (tx_done),
        .dout      (),
        .par_err   (),
        .frm_err   ()
    );
    asu_framer u_rx (
        .clock     (clock),
        .clr       (rst || !rx_on), // R5
        .tick      (op_tick),
        .is_rx     (1'b1),
        .go        (1'b0),
        .din       (8'h00),
        .line_in   (rx_line),
        .len7      (!mode_q[`ASU_BIT_CL]), // R14
        .lsb_first (ctrl_q[`ASU_BIT_DIR]),
        .par_mode  (par_mode),
        .stop2     (mode_q[`ASU_BIT_SL]),
        .busy      (),
        .line_out  (),
        .done      (rx_done),
        .dout      (rx_data),
        .par_err   (rx_perr),
        .frm_err   (rx_ferr)
    );
    // R1 R12 R16 R22 R17: serial function or plain port pin
    wire tx_port_mode = !port1_q[`ASU_BIT_TXPIN];
    assign serial_out_pin = tx_on ? (tx_line ^ invert) : tx_pin_latch;
    assign serial_out_oe  = tx_port_mode;
    assign rx_pin_oe      = !port1_q[`ASU_BIT_RXPIN];
    assign rx_pin_out     = rx_pin_latch;
    assign tx_done_pulse  = tx_done;
    assign rx_done_pulse  = rx_done;
    wire [7:0] tstat = {6'h00, txbf_q, tx_busy || txbf_q};
    wire [7:0] rd_mux =
        (reg_addr == `ASU_MODE_OFFSET)  ? mode_q :
        (reg_addr == `ASU_CTRL_OFFSET)  ? ctrl_q :
        (reg_addr == `ASU_PORT1_OFFSET) ? port1_q :
        (reg_addr == `ASU_DIV_OFFSET)   ? div_q :
        (reg_addr == `ASU_TXB_OFFSET)   ? txb_q :
        (reg_addr == `ASU_RXB_OFFSET)   ? rxb_q :
        (reg_addr == `ASU_ERR_OFFSET)   ? err_q :
        (reg_addr == `ASU_TSTAT_OFFSET) ? tstat : 8'h00;
    always_ff @(posedge clock) begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end
endmodule

// >>> asu_core_asserts.sv
// Port-level assertions for the serial unit core
`timescale 1ns/100ps
module asu_core_asserts (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_addr,
    input wire asu_pkg::asu_byte_t reg_wdata,
    input wire asu_pkg::asu_byte_t reg_rdata,
    input wire logic               tx_pin_latch,
    input wire logic               rx_pin_latch,
    input wire logic               serial_in_pin,
    input wire logic               serial_out_pin,
    input wire logic               serial_out_oe,
    input wire logic               rx_pin_oe,
    input wire logic               rx_pin_out,
    input wire logic               tx_done_pulse,
    input wire logic               rx_done_pulse
);
    import asu_pkg::*;
    logic [7:0]  mode_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  port_q;
    logic        act_q;
    logic [11:0] cnt_q;
    wire         tx_on = mode_q[7] && mode_q[6];
    wire         tx_go = reg_wr && reg_addr == 16'hff55 && tx_on && !act_q;
    wire  [11:0] nbits = 12'd2 + (mode_q[2] ? 12'd8 : 12'd7) + {11'd0, |mode_q[4:3]}
                         + {11'd0, mode_q[1]};
    // Frame length assumes divisor 4, as every run here sets
    wire  [11:0] fclk  = {nbits[5:0], 6'd0};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= 8'h01;
            ctrl_q <= 8'h16;
            port_q <= 8'hff;
        end else if (reg_wr) begin
            if (reg_addr == 16'hff50) mode_q <= reg_wdata;
            if (reg_addr == 16'hff58) ctrl_q <= reg_wdata;
            if (reg_addr == 16'hff21) port_q <= reg_wdata;
        end
    end
    always_ff @(posedge clock) begin
        act_q <= !rst && (tx_go || (act_q && !tx_done_pulse && tx_on));
        cnt_q <= tx_go ? 12'h000 : cnt_q + 12'h001;
    end
    chk_rdata_reset: assert property ($fell(rst) |-> reg_rdata == 8'h00)
        else $error("read data not cleared by reset");
    chk_mode_read: assert property (reg_rd && reg_addr == 16'hff50 |=> reg_rdata == $past(mode_q))
        else $error("mode register read mismatch");
    chk_tx_port: assert property (!tx_on |-> serial_out_pin == tx_pin_latch)
        else $error("transmit pin not in port mode");
    chk_pin_dir: assert property (serial_out_oe == !port_q[3] && rx_pin_oe == !port_q[4])
        else $error("pin direction mismatch");
    chk_rx_port: assert property (rx_pin_out == rx_pin_latch)
        else $error("receive pin latch not driven");
    chk_tx_idle: assert property (tx_on && !act_q |-> serial_out_pin == !ctrl_q[0])
        else $error("transmit line not idle");
    chk_tx_start: assert property (tx_go |-> ##[1:12] serial_out_pin == ctrl_q[0])
        else $error("no start bit after buffer write");
    chk_tx_len: assert property (tx_done_pulse && act_q |-> cnt_q >= fclk - 12'd40
                                 && cnt_q <= fclk + 12'd16)
        else $error("frame length wrong");
    chk_tx_pulse: assert property (tx_done_pulse |=> !tx_done_pulse)
        else $error("transmit done pulse too long");
    chk_rx_off: assert property (!mode_q[5] && !$past(mode_q[5]) |-> !rx_done_pulse)
        else $error("receive done while disabled");
endmodule
bind asu_core asu_core_asserts asu_core_asserts_i (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_pin_latch(tx_pin_latch), .rx_pin_latch(rx_pin_latch), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .rx_pin_oe(rx_pin_oe),
    .rx_pin_out(rx_pin_out), .tx_done_pulse(tx_done_pulse), .rx_done_pulse(rx_done_pulse));

// >>> asu_remote_node.sv
// Remote serial node model facing the unit's pins
`timescale 1ns/100ps
module asu_remote_node #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic   clock,
    input  wire logic   line_in,
    input  wire logic   inv,
    input  wire logic   listen,
    output logic        line_out,
    output logic [11:0] got,
    output int          got_cnt
);
    initial begin
        line_out = 1'b1;
        got = 12'h000;
        got_cnt = 0;
    end
    // Trailing ones of the frame leave the line idle high
    task automatic send(input logic [11:0] f);
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            #1;
            line_out = f[i];
            repeat (BIT_CLKS - 1) @(posedge clock);
        end
    endtask
    // Samples mid-bit; listens only when told, since port-mode levels look like starts
    always begin
        @(posedge clock);
        if (listen && (line_in ^ inv) == 1'b0) begin
            repeat (BIT_CLKS / 2) @(posedge clock);
            for (int i = 0; i < 12; i++) begin
                got[i] = line_in ^ inv;
                repeat (BIT_CLKS) @(posedge clock);
            end
            got_cnt++;
        end
    end
endmodule

// >>> tb_asu_core.sv
// Testbench for the serial unit core
`timescale 1ns/100ps
module tb_asu_core;
    import asu_pkg::*;
    localparam int BIT = 64;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, inv = 0, listen = 0;
    logic [15:0] reg_addr = 16'h0000;
    asu_byte_t reg_wdata = 8'h00, reg_rdata;
    logic tx_pin_latch = 1, rx_pin_latch = 1, serial_in_pin, serial_out_pin;
    logic serial_out_oe, rx_pin_oe, rx_pin_out, tx_done_pulse, rx_done_pulse;
    logic [11:0] got;
    int got_cnt, failures = 0, checks_done = 0, tx_dones = 0, rx_dones = 0;
    asu_byte_t tf[6] = '{8'h0c, 8'h0c, 8'h0c, 8'h12, 8'h04, 8'h1e};
    asu_byte_t tc[6] = '{8'h16, 8'h14, 8'h15, 8'h16, 8'h16, 8'h14};
    asu_byte_t td[6] = '{8'h55, 8'h55, 8'h55, 8'h36, 8'h87, 8'hc3};
    asu_byte_t rf[6] = '{8'h0c, 8'h0c, 8'h12, 8'h1c, 8'h04, 8'h12};
    asu_byte_t rd_v[6] = '{8'h55, 8'h55, 8'h36, 8'h81, 8'h87, 8'h36};
    logic rb[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    asu_byte_t re[6] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        if (tx_done_pulse === 1'b1) tx_dones++;
        if (rx_done_pulse === 1'b1) rx_dones++;
    end
    asu_core asu_core_i (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_pin_latch(tx_pin_latch), .rx_pin_latch(rx_pin_latch),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .rx_pin_oe(rx_pin_oe), .rx_pin_out(rx_pin_out),
        .tx_done_pulse(tx_done_pulse), .rx_done_pulse(rx_done_pulse));
    asu_remote_node #(.BIT_CLKS(BIT)) asu_remote_node_i (.clock(clock),
        .line_in(serial_out_pin), .inv(inv), .listen(listen), .line_out(serial_in_pin),
        .got(got), .got_cnt(got_cnt));
    // Frame bits in line order, start at bit 0, padded with idle ones
    function automatic logic [11:0] frame(input asu_byte_t d, input asu_byte_t m,
                                          input logic lsb, input logic bad);
        logic [11:0] f;
        int n;
        logic p;
        f = 12'hffe;
        n = m[2] ? 8 : 7;
        p = ^(d & (m[2] ? 8'hff : 8'h7f));
        for (int i = 0; i < n; i++) f[1 + i] = lsb ? d[i] : d[n - 1 - i];
        if (m[4:3] == 2'b01) f[n + 1] = p ^ bad;
        if (m[4:3] == 2'b10) f[n + 1] = !p ^ bad;
        if (m[4:3] == 2'b11) f[n + 1] = bad;
        return f;
    endfunction
    task automatic conclude();
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input asu_byte_t d);
        @(posedge clock);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input asu_byte_t exp);
        @(posedge clock);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        @(posedge clock);
        #1;
        chk($sformatf("register %h", a), {4'h0, exp}, {4'h0, reg_rdata});
    endtask
    // Format before power, power before enables, in the order R8 and R10 ask for
    task automatic setup(input asu_byte_t fmt, input asu_byte_t ctl, input asu_byte_t en);
        wr(16'hff50, fmt);
        wr(16'hff58, ctl);
        wr(16'hff50, fmt | 8'h80);
        wr(16'hff50, fmt | en);
    endtask
    task automatic stop(input asu_byte_t fmt);
        wr(16'hff50, fmt | 8'h80);
        wr(16'hff50, fmt);
    endtask
    task automatic rx_frame(input int k, input asu_byte_t en);
        int r0;
        logic lsb;
        lsb = !k[0];
        setup(rf[k], lsb ? 8'h16 : 8'h14, en);
        r0 = rx_dones;
        asu_remote_node_i.send(frame(rd_v[k], rf[k], lsb, rb[k]));
        repeat (BIT) @(posedge clock);
        chk("rx done", r0 + en[5], rx_dones);
        if (en[5]) rchk(16'hff53, rd_v[k] & (rf[k][2] ? 8'hff : 8'h7f));
        if (en[5]) rchk(16'hff52, re[k]);
        stop(rf[k]);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        failures++;
        conclude();
    end
    initial begin
        int c0, t0;
        repeat (10) @(posedge clock);
        #1;
        rst = 0;
        rchk(16'hff50, 8'h01);
        rchk(16'hff58, 8'h16);
        rchk(16'hff21, 8'hff);
        rchk(16'hff00, 8'h00);
        wr(16'hff57, 8'h04);
        wr(16'hff21, 8'hf7);
        chk("pin oe", 12'h002, {10'h000, serial_out_oe, rx_pin_oe});
        wr(16'hff55, 8'haa);
        rchk(16'hff56, 8'h00);
        for (int k = 0; k < 6; k++) begin
            setup(tf[k], tc[k], 8'he0);
            inv = tc[k][0];
            listen = 1'b1;
            c0 = got_cnt;
            t0 = tx_dones;
            wr(16'hff55, td[k]);
            repeat (13 * BIT) @(posedge clock);
            listen = 1'b0;
            chk("tx frame", frame(td[k], tf[k], tc[k][1], 1'b0), got);
            chk("tx count", c0 + 1, got_cnt);
            chk("tx done", t0 + 1, tx_dones);
            stop(tf[k]);
        end
        for (int k = 0; k < 6; k++) rx_frame(k, 8'ha0);
        rx_frame(0, 8'hc0);
        setup(8'h0c, 8'h16, 8'he0);
        inv = 1'b0;
        listen = 1'b1;
        fork
            wr(16'hff55, 8'ha5);
            asu_remote_node_i.send(frame(8'h3c, 8'h0c, 1'b1, 1'b0));
        join
        repeat (2 * BIT) @(posedge clock);
        listen = 1'b0;
        chk("duplex tx", frame(8'ha5, 8'h0c, 1'b1, 1'b0), got);
        rchk(16'hff53, 8'h3c);
        setup(8'h0c, 8'h16, 8'ha0);
        asu_remote_node_i.send(frame(8'h5a, 8'h0c, 1'b1, 1'b1));
        wr(16'hff50, 8'h8c);
        rchk(16'hff53, 8'h5a);
        wr(16'hff50, 8'h0c);
        rchk(16'hff52, 8'h00);
        rchk(16'hff53, 8'h00);
        rchk(16'hff56, 8'h00);
        tx_pin_latch = 1'b0;
        rx_pin_latch = 1'b0;
        repeat (2) @(posedge clock);
        chk("port pins", 12'h000, {10'h000, serial_out_pin, rx_pin_out});
        conclude();
    end
endmodule
